// ---- pkg/spi_chain_map.svh ----
// Function
// - Input frame is command byte then data byte
// - Output frame is status byte then report byte
// - Select high: ignore pins, release output
// - Launch on rising edge, sample on falling
// - All bytes shift most significant bit first
// - Wrong clock count flags error, drops write
// - Command: type bit, read bit, address
// - Status: two ones, digest, four fault flags, frame error
// - Report returns register content before write
// - Up to sixty-three devices share one select
// - Output: statuses, echoed headers, then reports
// - Header bytes lead with one then zero
// - First header counts devices; zero is error
// - Second header clear bit acts at select rise
// - Pass bytes forwarded one byte later
// - Count status bytes to find own slot
// - Chained bytes keep standard frame layout
// - Lock bits block configuration and output writes
// - Undefined address is blocked and flags error
// - Frame error reports the previous frame
// - Digest is OR of all fault flags
`ifndef SPI_CHAIN_MAP_SVH
`define SPI_CHAIN_MAP_SVH

// ****************************************************************
// Frame layout
// ****************************************************************
`define BYTE_LAST_BIT 3'h7
`define STD_FRAME_BYTES 8'h02
`define BYTE_CNT_MAX 8'hFF
`define TAG_HEADER 2'h2
`define TAG_PASS 2'h3
`define TYPE_BIT 7
`define RW_BIT 6
`define CLEAR_BIT 5
`define STATUS_TOP 2'h3
`define CHAIN_MAX 6'h3F

// ****************************************************************
// Register addresses
// ****************************************************************
`define ADDR_RO_LAST 6'h03
`define ADDR_COMMAND 6'h08
`define ADDR_OUT_CTRL 6'h09
`define ADDR_CFG_FIRST 6'h0A
`define ADDR_CFG_LAST 6'h0D

`endif

// ---- pkg/spi_chain_pkg.sv ----
package spi_chain_pkg;

  // ****************************************************************
  // Frame decoding state
  // ****************************************************************
  typedef enum logic [1:0] {
    MODE_IDLE = 2'h0,
    MODE_STD = 2'h1,
    MODE_HUNT = 2'h2,
    MODE_CHAIN = 2'h3
  } frame_mode_e;

  typedef logic [7:0] byte_t;

endpackage

// ---- logic/spi_write_buffer.sv ----
`timescale 1ns/1ps
module spi_write_buffer #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [CW-1:0] count;
  logic push;
  logic pop;

  // Handshakes
  assign in_ready = (count != CW'(DEPTH));
  assign out_valid = (count != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_ptr];

  // Storage entries
  generate
    for (genvar i = 0; i < DEPTH; i++) begin : g_entry
      always_ff @(posedge mclk) begin
        if (!rst_n) begin
          mem[i] <= '0;
        end else if (push && wr_ptr == PW'(i)) begin
          mem[i] <= in_data;
        end
      end
    end
  endgenerate

  // Pointers and fill count
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end

endmodule // spi_write_buffer

// ---- logic/spi_chain_port.sv ----
`timescale 1ns/1ps
`include "spi_chain_map.svh"
module spi_chain_port import spi_chain_pkg::*; #(
  parameter int BUF_DEPTH = 2
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Serial pins
  input wire logic chip_select_n,
  input wire logic sclk,
  input wire logic sdi,
  output logic sdo,
  output logic sdo_oe_n,
  // Fault flags from the monitors
  input wire logic por_flag,
  input wire logic supply_overvolt_flag,
  input wire logic supply_undervolt_flag,
  input wire logic overcurrent_flag,
  input wire logic overtemp_flag,
  input wire logic open_load_flag,
  // Lock state
  input wire logic config_lock,
  input wire logic output_lock,
  // Register read port
  output logic [5:0] reg_addr,
  input wire logic [7:0] reg_rdata,
  // Register write stream
  output logic wr_valid,
  input wire logic wr_ready,
  output logic [5:0] wr_addr,
  output logic [7:0] wr_data,
  // Status
  output logic frame_error_flag,
  output logic error_digest,
  output logic clear_errors_cmd,
  output logic chain_active,
  output logic [5:0] chain_position
);

  // ****************************************************************
  // Pin synchronisers and edge detection
  // ****************************************************************
  logic [2:0] cs_sync;
  logic [2:0] sclk_sync;
  logic [1:0] sdi_sync;
  logic cs_low;
  logic cs_fall;
  logic cs_rise;
  logic sclk_rise;
  logic sclk_fall;

  // Two flops per pin, a third stage for edges
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cs_sync <= 3'h7;
      sclk_sync <= 3'h0;
      sdi_sync <= 2'h0;
    end else begin
      cs_sync <= {cs_sync[1:0], chip_select_n};
      sclk_sync <= {sclk_sync[1:0], sclk};
      sdi_sync <= {sdi_sync[0], sdi};
    end
  end

  // Clock edges only count while selected
  assign cs_low = !cs_sync[1];
  assign cs_fall = !cs_sync[1] && cs_sync[2];
  assign cs_rise = cs_sync[1] && !cs_sync[2];
  assign sclk_rise = cs_low && sclk_sync[1] && !sclk_sync[2];
  assign sclk_fall = cs_low && !sclk_sync[1] && sclk_sync[2];

  // ****************************************************************
  // Input shifter and counters
  // ****************************************************************
  logic [2:0] bit_cnt;
  byte_t shift_in;
  byte_t next_shift;
  logic [7:0] byte_cnt;
  logic byte_done;
  logic [1:0] tag;

  assign next_shift = {shift_in[6:0], sdi_sync[1]};
  assign byte_done = sclk_fall && (bit_cnt == `BYTE_LAST_BIT);
  assign tag = next_shift[7:6];

  // Bit counter and shifter, cleared at either select edge
  always_ff @(posedge mclk) begin
    if (!rst_n || cs_fall || cs_rise) begin
      bit_cnt <= 3'h0;
      shift_in <= 8'h00;
    end else if (sclk_fall) begin
      bit_cnt <= bit_cnt + 3'h1;
      shift_in <= next_shift;
    end
  end

  // Count of whole bytes in this frame, saturating
  always_ff @(posedge mclk) begin
    if (!rst_n || cs_fall) begin
      byte_cnt <= 8'h00;
    end else if (byte_done && byte_cnt != `BYTE_CNT_MAX) begin
      byte_cnt <= byte_cnt + 8'h01;
    end
  end

  // ****************************************************************
  // Frame decoding
  // ****************************************************************
  frame_mode_e mode;
  byte_t cmd;
  byte_t wdata;
  logic [5:0] chain_n;
  logic [5:0] pos;
  logic clr_req;
  logic bad_frame;
  logic cmd_seen;
  logic cmd_hit;
  logic [7:0] chain_control_header_idx;
  logic [7:0] cmd_idx;
  logic [7:0] data_idx;
  logic [7:0] chain_bytes;

  // Own slots are fixed once the count is known
  assign chain_control_header_idx = {2'h0, pos} + 8'h01;
  assign cmd_idx = {2'h0, chain_n} + 8'h01;
  assign data_idx = {1'b0, chain_n, 1'b0} + 8'h01;
  assign chain_bytes = {1'b0, chain_n, 1'b0} + `STD_FRAME_BYTES;

  // Command byte arrival, first byte or own chain slot
  assign cmd_hit = byte_done && ((mode == MODE_IDLE && tag[1] == 1'b0) ||
                                 (mode == MODE_CHAIN && byte_cnt == cmd_idx));

  // Frame type, chain position and own command and data capture
  always_ff @(posedge mclk) begin
    if (!rst_n || cs_fall) begin
      mode <= MODE_IDLE;
      cmd <= 8'h00;
      wdata <= 8'h00;
      chain_n <= 6'h00;
      pos <= 6'h00;
      clr_req <= 1'b0;
      bad_frame <= 1'b0;
      cmd_seen <= 1'b0;
    end else if (byte_done) begin
      unique case (mode)
        MODE_IDLE: begin
          if (tag == `TAG_PASS) begin
            mode <= MODE_HUNT;
            pos <= 6'h01;
          end else if (tag == `TAG_HEADER) begin
            mode <= MODE_CHAIN;
            chain_n <= next_shift[5:0];
            if (next_shift[5:0] == 6'h00) begin
              bad_frame <= 1'b1;
            end
          end else begin
            mode <= MODE_STD;
            cmd <= next_shift;
            cmd_seen <= 1'b1;
          end
        end
        MODE_STD: begin
          if (byte_cnt == 8'h01) begin
            wdata <= next_shift;
          end
        end
        MODE_HUNT: begin
          if (tag == `TAG_PASS) begin
            if (pos == `CHAIN_MAX) begin
              bad_frame <= 1'b1;
            end else begin
              pos <= pos + 6'h01;
            end
          end else if (tag == `TAG_HEADER) begin
            mode <= MODE_CHAIN;
            chain_n <= next_shift[5:0];
            if (next_shift[5:0] == 6'h00 || next_shift[5:0] <= pos) begin
              bad_frame <= 1'b1;
            end
          end else begin
            bad_frame <= 1'b1;
          end
        end
        MODE_CHAIN: begin
          if (byte_cnt == chain_control_header_idx) begin
            clr_req <= next_shift[`CLEAR_BIT];
            if (tag != `TAG_HEADER) begin
              bad_frame <= 1'b1;
            end
          end
          if (cmd_hit) begin
            cmd <= next_shift;
            cmd_seen <= 1'b1;
          end
          if (byte_cnt == data_idx) begin
            wdata <= next_shift;
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // Address map and locks
  // ****************************************************************
  function automatic logic addr_defined(input logic [5:0] a);
    addr_defined = (a <= `ADDR_RO_LAST) || (a >= `ADDR_COMMAND && a <= `ADDR_CFG_LAST);
  endfunction

  function automatic logic addr_writable(input logic [5:0] a);
    addr_writable = (a >= `ADDR_COMMAND && a <= `ADDR_CFG_LAST);
  endfunction

  // Lock register itself stays writable so software can unlock
  function automatic logic addr_locked(input logic [5:0] a, input logic cfg, input logic outc);
    addr_locked = (cfg && a >= `ADDR_CFG_FIRST && a <= `ADDR_CFG_LAST) || (outc && a == `ADDR_OUT_CTRL);
  endfunction

  // Read address follows the captured command
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      reg_addr <= 6'h00;
    end else if (cmd_hit) begin
      reg_addr <= next_shift[5:0];
    end
  end

  // ****************************************************************
  // Output shifter
  // ****************************************************************
  logic report_pending;
  byte_t out_sr;
  byte_t status_byte;

  // Status byte: two ones, digest, overvolt, undervolt, overcurrent, overtemp, frame error
  assign status_byte = {`STATUS_TOP, error_digest, supply_overvolt_flag, supply_undervolt_flag,
                        overcurrent_flag, overtemp_flag, frame_error_flag};

  // Report loads one cycle after the command, once the read data settles
  always_ff @(posedge mclk) begin
    if (!rst_n || cs_fall) begin
      report_pending <= 1'b0;
    end else begin
      report_pending <= cmd_hit;
    end
  end

  // Next byte to send: status first, then forwarded or report bytes
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      out_sr <= 8'h00;
      sdo <= 1'b0;
    end else if (cs_fall) begin
      out_sr <= status_byte;
    end else if (report_pending) begin
      out_sr <= addr_defined(reg_addr) ? reg_rdata : 8'h00;
    end else if (byte_done) begin
      out_sr <= next_shift;
    end else if (sclk_rise) begin
      sdo <= out_sr[7];
      out_sr <= {out_sr[6:0], 1'b0};
    end
  end

  // Output released whenever select is high
  assign sdo_oe_n = !cs_low;

  // ****************************************************************
  // Frame check and commit at select rise
  // ****************************************************************
  logic len_ok;
  logic frame_ok;
  logic write_req;
  logic err_now;
  logic push_ready;

  // Clock count must be exactly a whole standard or chain frame
  assign len_ok = (bit_cnt == 3'h0) && !bad_frame &&
                  ((mode == MODE_STD && byte_cnt == `STD_FRAME_BYTES) ||
                   (mode == MODE_CHAIN && byte_cnt == chain_bytes));
  assign frame_ok = len_ok && cmd_seen && !cmd[`TYPE_BIT];
  assign write_req = frame_ok && !cmd[`RW_BIT] && addr_writable(cmd[5:0]) &&
                     !addr_locked(cmd[5:0], config_lock, output_lock);
  assign err_now = !frame_ok || !addr_defined(cmd[5:0]) || (write_req && !push_ready);

  // Frame error shows in the status of the next frame
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      frame_error_flag <= 1'b0;
    end else if (cs_rise) begin
      frame_error_flag <= err_now;
    end
  end

  // Digest and global clear pulse
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      error_digest <= 1'b0;
      clear_errors_cmd <= 1'b0;
    end else begin
      error_digest <= frame_error_flag | por_flag | supply_overvolt_flag | supply_undervolt_flag |
                      overcurrent_flag | overtemp_flag | open_load_flag;
      clear_errors_cmd <= cs_rise && frame_ok && mode == MODE_CHAIN && clr_req;
    end
  end

  // Chain position kept from the last whole-length frame; a standard frame sets it to zero
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      chain_active <= 1'b0;
      chain_position <= 6'h00;
    end else if (cs_rise && len_ok) begin
      chain_active <= (mode == MODE_CHAIN);
      chain_position <= (mode == MODE_CHAIN) ? pos : 6'h00;
    end
  end

  // ****************************************************************
  // Write stream buffer
  // ****************************************************************
  logic [13:0] push_data;
  logic [13:0] pop_data;

  assign push_data = {cmd[5:0], wdata};
  assign wr_addr = pop_data[13:8];
  assign wr_data = pop_data[7:0];

  // Writes enter the buffer only at select rise after a valid frame
  spi_write_buffer #(
    .WIDTH(14),
    .DEPTH(BUF_DEPTH)
  ) u_wbuf (
    .mclk(mclk),
    .rst_n(rst_n),
    .in_valid(cs_rise && write_req),
    .in_ready(push_ready),
    .in_data(push_data),
    .out_valid(wr_valid),
    .out_ready(wr_ready),
    .out_data(pop_data)
  );

endmodule // spi_chain_port

// ---- tb/spi_chain_port_properties.sv ----
`timescale 1ns/1ps
module spi_chain_port_check (
  // Clock and reset
  input logic mclk,
  input logic rst_n,
  // Serial pins
  input logic chip_select_n,
  input logic sclk,
  input logic sdo,
  input logic sdo_oe_n,
  // Fault inputs
  input logic por_flag,
  input logic supply_overvolt_flag,
  input logic supply_undervolt_flag,
  input logic overcurrent_flag,
  input logic overtemp_flag,
  input logic open_load_flag,
  // Write stream
  input logic wr_valid,
  input logic wr_ready,
  input logic [5:0] wr_addr,
  input logic [7:0] wr_data,
  // Status
  input logic frame_error_flag,
  input logic error_digest,
  input logic clear_errors_cmd,
  input logic [5:0] chain_position
);
  logic any_fault;

  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  // Raw OR that the digest must follow one cycle later
  assign any_fault = frame_error_flag | por_flag | supply_overvolt_flag | supply_undervolt_flag |
    overcurrent_flag | overtemp_flag | open_load_flag;

  // ****
  // Serial pins
  // ****
  chk_idle_release: assert property (chip_select_n [*4] |-> sdo_oe_n)
    else $error("sdo driven while select high");
  chk_select_drive: assert property ($fell(chip_select_n) |-> ##[1:5] !sdo_oe_n)
    else $error("sdo not driven after select fall");
  chk_launch_rise: assert property (!sdo_oe_n && !$past(sdo_oe_n, 3) && $changed(sdo) |->
    $past(sclk, 2) || $past(sclk, 3) || $past(sclk, 4) || $past(sclk, 5))
    else $error("sdo changed away from a clock rise");

  // ****
  // Writes and status
  // ****
  chk_write_commit: assert property ($rose(wr_valid) |-> $past(chip_select_n, 3))
    else $error("write pushed inside a frame");
  chk_write_hold: assert property (wr_valid && !wr_ready |=> wr_valid && $stable(wr_addr) && $stable(wr_data))
    else $error("stalled write word lost or changed");
  chk_digest_or: assert property ($past(rst_n) |-> error_digest == $past(any_fault))
    else $error("digest is not the OR of the flags");
  chk_clear_pulse: assert property (clear_errors_cmd |-> chip_select_n ##1 !clear_errors_cmd)
    else $error("clear pulse outside select rise");
  chk_error_frame: assert property ($changed(frame_error_flag) |-> chip_select_n && $past(chip_select_n))
    else $error("frame error changed inside a frame");
  chk_slot_steady: assert property ($changed(chain_position) |-> chip_select_n)
    else $error("chain position changed inside a frame");
endmodule // spi_chain_port_check

bind spi_chain_port spi_chain_port_check spi_chain_port_check_i (
  .mclk, .rst_n, .chip_select_n, .sclk, .sdo, .sdo_oe_n,
  .por_flag, .supply_overvolt_flag, .supply_undervolt_flag, .overcurrent_flag, .overtemp_flag, .open_load_flag,
  .wr_valid, .wr_ready, .wr_addr, .wr_data,
  .frame_error_flag, .error_digest, .clear_errors_cmd, .chain_position
);

// ---- tb/spi_host_model.sv ----
`timescale 1ns/1ps
module spi_host_model (
  // Serial pins
  output logic chip_select_n,
  output logic sclk,
  output logic sdi,
  input wire logic sdo,
  input wire logic sdo_oe_n
);
  logic last = 1'b0;
  logic line;

  // Released output shows the inverse of its last driven level
  assign line = sdo_oe_n ? ~last : sdo;
  always @(sdo or sdo_oe_n) if (!sdo_oe_n) last = sdo;

  // Idle pins
  initial begin
    chip_select_n = 1'b1;
    sclk = 1'b0;
    sdi = 1'b0;
  end

  // One frame, first bit at tx[63], received bits gathered at the low end
  task automatic xfer(input logic [63:0] tx, input int nbits, output logic [63:0] rx);
    rx = '0;
    chip_select_n = 1'b0;
    #64;
    for (int i = 0; i < nbits; i++) begin
      sclk = 1'b1;
      sdi = tx[63 - i];
      #32 sclk = 1'b0;
      #32 rx = {rx[62:0], line};
    end
    chip_select_n = 1'b1;
    sdi = ~sdi;
    #200;
  endtask
endmodule // spi_host_model

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
module testbench import spi_chain_pkg::*;;
  typedef struct packed {
    byte_t cmd;
    byte_t data;
    logic [5:0] faults;
    logic [1:0] locks;
    logic wr;
    logic err;
  } row_s;

  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [5:0] faults = 6'h00;
  logic config_lock = 1'b0;
  logic output_lock = 1'b0;
  logic wr_ready = 1'b1;
  logic chip_select_n, sclk, sdi, sdo, sdo_oe_n, wr_valid;
  logic frame_error_flag, error_digest, clear_errors_cmd, chain_active;
  logic [5:0] reg_addr, wr_addr, chain_position;
  logic [7:0] reg_rdata, wr_data;
  logic [63:0] rx;
  logic [13:0] last_w;
  logic prev_err = 1'b0;
  int mismatches = 0;
  int comparisons = 0;
  int pops = 0;
  int clears = 0;
  row_s rows [8];

  // ****
  // Clock, register content, design and host
  // ****
  always #4 mclk = ~mclk;
  assign reg_rdata = {reg_addr, 2'h1};

  spi_chain_port #(.BUF_DEPTH(2)) spi_chain_port_i (
    .mclk(mclk), .rst_n(rst_n), .chip_select_n(chip_select_n), .sclk(sclk), .sdi(sdi),
    .sdo(sdo), .sdo_oe_n(sdo_oe_n), .por_flag(faults[5]), .supply_overvolt_flag(faults[4]),
    .supply_undervolt_flag(faults[3]), .overcurrent_flag(faults[2]), .overtemp_flag(faults[1]),
    .open_load_flag(faults[0]), .config_lock(config_lock), .output_lock(output_lock),
    .reg_addr(reg_addr), .reg_rdata(reg_rdata), .wr_valid(wr_valid), .wr_ready(wr_ready),
    .wr_addr(wr_addr), .wr_data(wr_data), .frame_error_flag(frame_error_flag),
    .error_digest(error_digest), .clear_errors_cmd(clear_errors_cmd),
    .chain_active(chain_active), .chain_position(chain_position)
  );

  spi_host_model spi_host_model_i (
    .chip_select_n(chip_select_n), .sclk(sclk), .sdi(sdi), .sdo(sdo), .sdo_oe_n(sdo_oe_n)
  );

  // Count accepted writes and clear pulses
  always @(posedge mclk) begin
    if (wr_valid && wr_ready) begin
      pops <= pops + 1;
      last_w <= {wr_addr, wr_data};
    end
    if (clear_errors_cmd) clears <= clears + 1;
  end

  // ****
  // Checking and verdict
  // ****
  task automatic check(input string name, input logic [47:0] seen, input logic [47:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("Comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // ****
  // Main sequence
  // ****
  initial begin
    int n;
    logic [5:0] a;
    logic [7:0] rep;
    rows = '{'{8'h08, 8'h5A, 6'h21, 2'h0, 1'b1, 1'b0}, '{8'h41, 8'h00, 6'h10, 2'h0, 1'b0, 1'b0},
      '{8'h09, 8'hC3, 6'h08, 2'h1, 1'b0, 1'b0}, '{8'h09, 8'hC3, 6'h00, 2'h2, 1'b1, 1'b0},
      '{8'h0A, 8'h3C, 6'h04, 2'h2, 1'b0, 1'b0}, '{8'h0A, 8'h96, 6'h02, 2'h1, 1'b1, 1'b0},
      '{8'h60, 8'h00, 6'h00, 2'h0, 1'b0, 1'b1}, '{8'h02, 8'hFF, 6'h00, 2'h3, 1'b0, 1'b0}};
    repeat (5) @(negedge mclk);
    check("oe in reset", sdo_oe_n, 1'b1);
    check("valid in reset", wr_valid, 1'b0);
    rst_n = 1'b1;
    foreach (rows[k]) begin
      @(negedge mclk);
      {config_lock, output_lock} = rows[k].locks;
      faults = rows[k].faults;
      n = pops;
      repeat (2) @(negedge mclk);
      spi_host_model_i.xfer({rows[k].cmd, rows[k].data, 48'h0}, 16, rx);
      a = rows[k].cmd[5:0];
      rep = (a <= 6'h03 || (a >= 6'h08 && a <= 6'h0D)) ? {a, 2'h1} : 8'h00;
      check("status", rx[15:8], {2'h3, prev_err | (|faults), faults[4:1], prev_err});
      check("report", rx[7:0], rep);
      check("frame error", frame_error_flag, rows[k].err);
      check("write count", pops - n, rows[k].wr);
      if (rows[k].wr) check("write word", last_w, {a, rows[k].data});
      prev_err = rows[k].err;
    end
    // Short frame drops the write
    @(negedge mclk);
    n = pops;
    spi_host_model_i.xfer({8'h08, 8'h11, 48'h0}, 15, rx);
    check("short error", frame_error_flag, 1'b1);
    check("short writes", pops - n, 0);
    // Stalled sink: two words held, third refused
    @(negedge mclk);
    wr_ready = 1'b0;
    n = pops;
    for (int i = 1; i <= 3; i++) spi_host_model_i.xfer({8'h08, 8'(i * 17), 48'h0}, 16, rx);
    check("full error", frame_error_flag, 1'b1);
    check("held word", {wr_valid, wr_addr, wr_data}, {1'b1, 6'h08, 8'h11});
    @(negedge mclk);
    wr_ready = 1'b1;
    for (int i = 0; i < 20 && wr_valid; i++) @(negedge mclk);
    check("drained", {wr_valid, 8'(pops - n), last_w}, {1'b0, 8'h02, 6'h08, 8'h22});
    // Chain of two, this device second, clear bit set
    n = clears;
    spi_host_model_i.xfer({8'hC5, 8'h82, 8'hA0, 8'h48, 8'h77, 8'h00, 16'h0}, 48, rx);
    check("chain out", rx[47:0], {8'hE1, 8'hC5, 8'h82, 8'hA0, 8'h21, 8'h77});
    check("chain state", {chain_active, chain_position, frame_error_flag}, {1'b1, 6'h01, 1'b0});
    check("clear pulses", clears - n, 1);
    // Zero device count
    spi_host_model_i.xfer({8'h80, 8'h80, 48'h0}, 16, rx);
    check("zero count", frame_error_flag, 1'b1);
    spi_host_model_i.xfer({8'h41, 8'h00, 48'h0}, 16, rx);
    check("status after", rx[15:0], {8'hE1, 8'h05});
    // Chain of one, this device nearest, write with clear bit off
    n = pops;
    spi_host_model_i.xfer({8'h81, 8'h80, 8'h08, 8'h3C, 32'h0}, 32, rx);
    check("chain write out", rx[31:0], {8'hC0, 8'h81, 8'h80, 8'h21});
    check("chain write", {8'(pops - n), last_w, chain_active, chain_position, 8'(clears), frame_error_flag},
          {8'h01, 6'h08, 8'h3C, 1'b1, 6'h00, 8'h01, 1'b0});
    // Pass byte, then a count that leaves no slot for this device
    spi_host_model_i.xfer({8'hC7, 8'h81, 48'h0}, 16, rx);
    check("pass forward", rx[15:0], {8'hC0, 8'hC7});
    check("count below slot", {frame_error_flag, chain_position}, {1'b1, 6'h00});
    // Reset in mid-run, then a read starts clean
    @(negedge mclk);
    rst_n = 1'b0;
    repeat (3) @(negedge mclk);
    check("after reset", {frame_error_flag, error_digest, chain_active, wr_valid, sdo_oe_n}, 5'h01);
    rst_n = 1'b1;
    @(negedge mclk);
    spi_host_model_i.xfer({8'h41, 8'h00, 48'h0}, 16, rx);
    check("read after reset", rx[15:0], {8'hC0, 8'h05});
    conclude();
  end
endmodule // testbench
